// >>> src/mas_conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mas_defines.svh"
module mas_conv_timer import mas_pkg::*; #(
  parameter int CONV_CYCLES = `MAS_CONV_TIME_NS / `MAS_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  output logic done
);
  mas_timer_type t_r;
  mas_timer_type t_nxt;

  // ==========================================================
  // conversion time counter
  always_comb begin
    t_nxt = t_r;
    t_nxt.done = 1'b0;
    if (start) begin
      t_nxt.cnt = 18'(CONV_CYCLES);
      t_nxt.busy = 1'b1;
    end else if (t_r.busy) begin
      if (t_r.cnt <= 18'h00001) begin
        t_nxt.busy = 1'b0;
        t_nxt.done = 1'b1;
        t_nxt.cnt = 18'h00000;
      end else begin
        t_nxt.cnt = t_r.cnt - 18'h00001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign done = t_r.done;
endmodule
`default_nettype wire

// >>> src/mas_defines.svh
`ifndef MAS_DEFINES_SVH
`define MAS_DEFINES_SVH
// Function
// - supply under undervoltage_threshold holds reset, clearing data and control.
// - during undervoltage the register port is refused and registers read zero.
// - remote temperature enables bias on first or third monitor input.
// - temperature is 13 bits, 9 integer and 4 fraction bits.
// - control selects Kelvin or Celsius temperature; Kelvin is unsigned.
// - each conversion takes nominally 1.5 ms before the result is used.
// - single-ended and differential results are 14 bits.
// - host writes control; single and repeated acquisition modes exist.
// - selected measurements always run in one fixed order.
// - order is internal temperature, inputs one to four, then supply.
// - trigger register write starts a single or repeated sequence.
// - repeated mode keeps cycling after one trigger.
// - storing a result sets its valid bit and its status bit.
// - addressing a data register clears its valid and status bits; here only a read of either byte clears them, a write does not.
// - power-up control value measures internal temperature only.
// - monitor inputs stay disconnected until configured and triggered.
// - upper and lower bytes of one read come from one conversion.
// - data updates wait while a data register read is in progress.
// - status register reads never pause data updates.

// ==========================================================
// register map
`define MAS_ADDR_STATUS 5'h00
`define MAS_ADDR_CONTROL 5'h01
`define MAS_ADDR_TRIGGER 5'h02
`define MAS_ADDR_DATA_BASE 5'h04
`define MAS_ADDR_DATA_LAST 5'h0F
`define MAS_CONTROL_RESET 8'h00

// ==========================================================
// control and status fields
`define MAS_CTRL_KELVIN 7
`define MAS_CTRL_REPEAT 6
`define MAS_CTRL_VCC_EN 4
`define MAS_CTRL_PAIRB_LO 2
`define MAS_CTRL_PAIRA_LO 0
`define MAS_MODE_OFF 2'h0
`define MAS_MODE_SINGLE 2'h1
`define MAS_MODE_DIFF 2'h2
`define MAS_MODE_TEMP 2'h3
`define MAS_STAT_BUSY 0
`define MAS_STAT_NEW_LO 1

// ==========================================================
// acquisition steps in fixed order
`define MAS_STEP_TINT 3'h0
`define MAS_STEP_V1 3'h1
`define MAS_STEP_V2 3'h2
`define MAS_STEP_V3 3'h3
`define MAS_STEP_V4 3'h4
`define MAS_STEP_VCC 3'h5
`define MAS_STEP_NONE 3'h7

// ==========================================================
// timing and formats
`define MAS_CLK_PERIOD_NS 8
`define MAS_CONV_TIME_NS 1500000
`define MAS_CELSIUS_OFFSET 13'h1112
`endif

// >>> src/mas_pkg.sv
package mas_pkg;
  `include "mas_defines.svh"

  typedef enum logic [1:0] {
    MAS_IDLE,
    MAS_START,
    MAS_WAIT,
    MAS_STORE
  } mas_state_type;

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
  } mas_sync_type;

  typedef struct packed {
    logic [17:0] cnt;
    logic busy;
    logic done;
  } mas_timer_type;

  typedef struct packed {
    mas_state_type state;
    logic [2:0] step;
    logic repeatOn;
    logic [7:0] ctrl;
    logic [5:0][13:0] res;
    logic [5:0] valid;
    logic [7:0] lsbHold;
    logic [2:0] holdIdx;
    logic holdOk;
    logic dataPtr;
    logic [7:0] rdata;
    logic adcStart;
    logic adcDiff;
    logic [2:0] muxSel;
    logic [1:0] biasEn;
    logic [3:0] inputEn;
    logic busy;
  } mas_seq_type;
endpackage

// >>> src/mas_sequencer.sv
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mas_defines.svh"
module mas_sequencer import mas_pkg::*; #(
  parameter int CONV_CYCLES = `MAS_CONV_TIME_NS / `MAS_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic uvDetect,
  input wire logic serialReadBusy,
  input wire logic [13:0] adcData,
  output logic adcStart,
  output logic adcDiff,
  output logic [2:0] muxSel,
  output logic [1:0] biasEn,
  output logic [3:0] inputEn,
  output logic seqBusy
);
  mas_seq_type s_r;
  mas_seq_type s_nxt;
  logic [15:0] syncOut;
  logic uvSync;
  logic readBusySync;
  logic [13:0] adcSync;
  logic convDone;

  // ==========================================================
  // pins from outside the clock domain
  mas_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({uvDetect, serialReadBusy, adcData}),
    .dout(syncOut)
  );

  assign uvSync = syncOut[15];
  assign readBusySync = syncOut[14];
  assign adcSync = syncOut[13:0];

  mas_conv_timer #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .start(s_r.adcStart),
    .done(convDone)
  );

  // ==========================================================
  // helpers
  function automatic logic [1:0] pairMode(input logic [7:0] c,
                                          input logic second);
    pairMode = second ? c[`MAS_CTRL_PAIRB_LO +: 2] :
                        c[`MAS_CTRL_PAIRA_LO +: 2];
  endfunction

  function automatic logic stepOn(input logic [2:0] st,
                                  input logic [7:0] c);
    stepOn = 1'b0;
    case (st)
      `MAS_STEP_TINT: stepOn = 1'b1;
      `MAS_STEP_V1: stepOn = pairMode(c, 1'b0) != `MAS_MODE_OFF;
      `MAS_STEP_V2: stepOn = pairMode(c, 1'b0) == `MAS_MODE_SINGLE;
      `MAS_STEP_V3: stepOn = pairMode(c, 1'b1) != `MAS_MODE_OFF;
      `MAS_STEP_V4: stepOn = pairMode(c, 1'b1) == `MAS_MODE_SINGLE;
      `MAS_STEP_VCC: stepOn = c[`MAS_CTRL_VCC_EN];
      default: stepOn = 1'b0;
    endcase
  endfunction

  // first selected step at or after 'from', fixed ascending order
  function automatic logic [2:0] nextStep(input logic [2:0] from,
                                          input logic [7:0] c);
    logic found;
    found = 1'b0;
    nextStep = `MAS_STEP_NONE;
    for (int i = 0; i <= 5; i++) begin
      if (!found && 3'(i) >= from && stepOn(3'(i), c)) begin
        nextStep = 3'(i);
        found = 1'b1;
      end
    end
  endfunction

  function automatic logic isTemp(input logic [2:0] st,
                                  input logic [7:0] c);
    isTemp = (st == `MAS_STEP_TINT) ||
             (st == `MAS_STEP_V1 && pairMode(c, 1'b0) == `MAS_MODE_TEMP) ||
             (st == `MAS_STEP_V3 && pairMode(c, 1'b1) == `MAS_MODE_TEMP);
  endfunction

  function automatic logic isData(input logic [4:0] a);
    isData = a >= `MAS_ADDR_DATA_BASE && a <= `MAS_ADDR_DATA_LAST;
  endfunction

  function automatic logic [2:0] dataIdx(input logic [4:0] a);
    logic [4:0] off;
    off = a - `MAS_ADDR_DATA_BASE;
    dataIdx = off[3:1];
  endfunction

  function automatic logic [7:0] msbByte(input logic [13:0] r,
                                         input logic v,
                                         input logic t);
    if (t) begin
      msbByte = {v, 2'b00, r[12:8]};
    end else begin
      msbByte = {v, r[13], r[13:8]};
    end
  endfunction

  // ==========================================================
  // sequencer and register port
  logic trigger;
  logic [2:0] rdIdx;
  logic [2:0] wrIdx;
  logic [12:0] tempVal;
  logic pause;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    s_nxt.adcStart = 1'b0;
    rdIdx = dataIdx(regAddr);
    wrIdx = s_r.step;
    trigger = regWrite && regAddr == `MAS_ADDR_TRIGGER;
    // only a read that points at a data register holds updates
    pause = readBusySync && s_r.dataPtr;
    tempVal = adcSync[12:0];
    if (!s_r.ctrl[`MAS_CTRL_KELVIN]) begin
      tempVal = adcSync[12:0] - `MAS_CELSIUS_OFFSET;
    end

    if (regWrite) begin
      s_nxt.dataPtr = isData(regAddr);
      if (regAddr == `MAS_ADDR_CONTROL) begin
        s_nxt.ctrl = regWdata;
      end
    end
    if (regRead) begin
      s_nxt.dataPtr = isData(regAddr);
      case (regAddr)
        `MAS_ADDR_STATUS: begin
          s_nxt.rdata = {1'b0, s_r.valid, s_r.state != MAS_IDLE};
        end
        `MAS_ADDR_CONTROL: s_nxt.rdata = s_r.ctrl;
        default: begin
          if (isData(regAddr)) begin
            s_nxt.valid[rdIdx] = 1'b0;
            if (!regAddr[0]) begin
              s_nxt.rdata = msbByte(s_r.res[rdIdx], s_r.valid[rdIdx],
                                    isTemp(rdIdx, s_r.ctrl));
              s_nxt.lsbHold = s_r.res[rdIdx][7:0];
              s_nxt.holdIdx = rdIdx;
              s_nxt.holdOk = 1'b1;
            end else begin
              s_nxt.holdOk = 1'b0;
              if (s_r.holdOk && s_r.holdIdx == rdIdx) begin
                s_nxt.rdata = s_r.lsbHold;
              end else begin
                s_nxt.rdata = s_r.res[rdIdx][7:0];
              end
            end
          end
        end
      endcase
    end

    case (s_r.state)
      MAS_IDLE: begin
        s_nxt.inputEn = 4'h0;
        s_nxt.biasEn = 2'b00;
        if (trigger) begin
          s_nxt.step = nextStep(`MAS_STEP_TINT, s_r.ctrl);
          s_nxt.repeatOn = s_r.ctrl[`MAS_CTRL_REPEAT];
          s_nxt.state = MAS_START;
        end
      end
      MAS_START: begin
        s_nxt.muxSel = s_r.step;
        s_nxt.adcDiff = s_r.step != `MAS_STEP_TINT &&
                        s_r.step != `MAS_STEP_VCC &&
                        !stepOn(3'(s_r.step + 3'h1), s_r.ctrl) &&
                        s_r.step != `MAS_STEP_V2 &&
                        s_r.step != `MAS_STEP_V4;
        s_nxt.inputEn = 4'h0;
        s_nxt.biasEn = 2'b00;
        case (s_r.step)
          `MAS_STEP_V1: begin
            s_nxt.inputEn = s_nxt.adcDiff ? 4'h3 : 4'h1;
            s_nxt.biasEn[0] = isTemp(s_r.step, s_r.ctrl);
          end
          `MAS_STEP_V2: s_nxt.inputEn = 4'h2;
          `MAS_STEP_V3: begin
            s_nxt.inputEn = s_nxt.adcDiff ? 4'hC : 4'h4;
            s_nxt.biasEn[1] = isTemp(s_r.step, s_r.ctrl);
          end
          `MAS_STEP_V4: s_nxt.inputEn = 4'h8;
          default: s_nxt.inputEn = 4'h0;
        endcase
        s_nxt.adcStart = 1'b1;
        s_nxt.state = MAS_WAIT;
      end
      MAS_WAIT: begin
        if (convDone) begin
          s_nxt.state = MAS_STORE;
        end
      end
      MAS_STORE: begin
        if (!pause) begin
          if (isTemp(wrIdx, s_r.ctrl)) begin
            s_nxt.res[wrIdx] = {1'b0, tempVal};
          end else begin
            s_nxt.res[wrIdx] = adcSync;
          end
          // set wins over a read clear in the same cycle
          s_nxt.valid[wrIdx] = 1'b1;
          // held low byte survives a store so a pair never mixes results
          s_nxt.biasEn = 2'b00;
          s_nxt.step = nextStep(3'(s_r.step + 3'h1), s_r.ctrl);
          s_nxt.state = MAS_START;
          if (nextStep(3'(s_r.step + 3'h1), s_r.ctrl) ==
              `MAS_STEP_NONE) begin
            if (s_r.repeatOn && s_r.ctrl[`MAS_CTRL_REPEAT]) begin
              s_nxt.step = nextStep(`MAS_STEP_TINT, s_r.ctrl);
            end else begin
              s_nxt.state = MAS_IDLE;
            end
          end
        end
      end
      default: s_nxt.state = MAS_IDLE;
    endcase

    // undervoltage wipes everything and refuses the port
    if (uvSync) begin
      s_nxt = '0;
      s_nxt.ctrl = `MAS_CONTROL_RESET;
    end
    // busy registered so the pin comes straight from a flop
    s_nxt.busy = s_nxt.state != MAS_IDLE;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign regRdata = s_r.rdata;
  assign adcStart = s_r.adcStart;
  assign adcDiff = s_r.adcDiff;
  assign muxSel = s_r.muxSel;
  assign biasEn = s_r.biasEn;
  assign inputEn = s_r.inputEn;
  assign seqBusy = s_r.busy;
endmodule
`default_nettype wire

// >>> src/mas_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mas_sync import mas_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  mas_sync_type s_r;
  mas_sync_type s_nxt;

  // ==========================================================
  // two-stage capture; first stage feeds only the second
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.s2;
endmodule
`default_nettype wire

// >>> verification/mas_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// converter stand-in
module mas_adc_model import mas_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic adcStart,
  input wire logic [2:0] muxSel,
  output logic [13:0] adcData
);
  // result held until the next start so the synced sample is clean
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      adcData <= 14'h0000;
    else if (adcStart)
      adcData <= 14'h1200 + {3'h0, muxSel, 5'h00, muxSel};
endmodule
`default_nettype wire

// >>> verification/mas_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "mas_defines.svh"
// ==========
// sequencer checks
module mas_sequencer_asserts import mas_pkg::*; #(
  parameter int CONV_CYCLES = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic uvDetect,
  input wire logic adcStart,
  input wire logic adcDiff,
  input wire logic [2:0] muxSel,
  input wire logic [1:0] biasEn,
  input wire logic [3:0] inputEn,
  input wire logic seqBusy
);
  // saturates so a long idle never wraps into a false short gap
  logic [31:0] gap_r;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      gap_r <= 32'hFFFFFFFF;
    else if (adcStart)
      gap_r <= 32'h00000000;
    else if (gap_r != 32'hFFFFFFFF)
      gap_r <= gap_r + 32'h00000001;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // uv must be low long enough for its synchroniser to settle
  sequence trigSeq;
    (!uvDetect) [*4] ##0
      (regWrite && regAddr == `MAS_ADDR_TRIGGER && !seqBusy);
  endsequence
  sequence startPulse;
    adcStart ##1 !adcStart;
  endsequence

  a_trig_busy: assert property (trigSeq |=> seqBusy)
    else $error("trigger did not raise busy");
  a_trig_start: assert property (trigSeq |-> ##2 startPulse)
    else $error("no conversion start after trigger");
  a_start_pulse: assert property (adcStart |-> startPulse)
    else $error("conversion start wider than one cycle");
  a_conv_gap: assert property (adcStart |-> gap_r >= CONV_CYCLES)
    else $error("conversion started before previous finished");
  a_bias_pos: assert property (|biasEn |-> adcDiff &&
    ({muxSel, biasEn} inside {5'h05, 5'h0E}))
    else $error("bias on wrong input");
  a_hiz_start: assert property ($rose(|inputEn) |-> adcStart)
    else $error("input connected without a conversion");
  a_uv_quiet: assert property (uvDetect [*6] |->
    !seqBusy && regRdata == 8'h00)
    else $error("activity during undervoltage");
  a_read_idle: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data outside read slot");
endmodule
bind mas_sequencer mas_sequencer_asserts #(.CONV_CYCLES(CONV_CYCLES))
  u_chk (
    .clk(clk),
    .resetn(resetn),
    .regAddr(regAddr),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .uvDetect(uvDetect),
    .adcStart(adcStart),
    .adcDiff(adcDiff),
    .muxSel(muxSel),
    .biasEn(biasEn),
    .inputEn(inputEn),
    .seqBusy(seqBusy)
  );
`default_nettype wire

// >>> verification/mas_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module mas_sequencer_tb;
  logic clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic uvDetect = 1'b0, serialReadBusy = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [13:0] adcData;
  logic adcStart, adcDiff, seqBusy;
  logic [2:0] muxSel;
  logic [1:0] biasEn, biasSeen = 2'h0;
  logic [3:0] inputEn, inSeen = 4'h0;
  logic [7:0] diffSeen = 8'h00;
  logic logClr = 1'b0;
  logic [23:0] stepLog = 24'hFFFFFF;
  int mismatches = 0, totalChecks = 0;

  mas_sequencer #(.CONV_CYCLES(20)) u_dut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .uvDetect(uvDetect),
    .serialReadBusy(serialReadBusy), .adcData(adcData),
    .adcStart(adcStart), .adcDiff(adcDiff), .muxSel(muxSel),
    .biasEn(biasEn), .inputEn(inputEn), .seqBusy(seqBusy)
  );
  mas_adc_model u_adc (
    .clk(clk), .resetn(resetn), .adcStart(adcStart),
    .muxSel(muxSel), .adcData(adcData)
  );

  initial forever #4 clk = ~clk;
  // one nibble per conversion start, newest lowest
  always @(posedge clk)
    if (logClr) begin
      stepLog <= 24'hFFFFFF;
      biasSeen <= 2'h0;
      inSeen <= 4'h0;
      diffSeen <= 8'h00;
    end else if (adcStart === 1'b1) begin
      stepLog <= {stepLog[19:0], 1'b0, muxSel};
      biasSeen <= biasSeen | biasEn;
      inSeen <= inSeen | inputEn;
      diffSeen[muxSel] <= adcDiff;
    end

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    totalChecks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(24'(regRdata), 24'(e));
    @(posedge clk);
  endtask
  task trig;
    logClr <= 1'b1;
    wr(5'h02, 8'h00);
    logClr <= 1'b0;
  endtask
  task automatic wait_idle;
    int n = 0;
    #1;
    while (seqBusy !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(24'(seqBusy), 24'h0);
    @(posedge clk);
  endtask

  task t_reset;
    rd(5'h01, 8'h00);
    chk(24'(inputEn), 24'h0);
    wr(5'h03, 8'hFF);
    rd(5'h03, 8'h00);
    rd(5'h10, 8'h00);
  endtask
  task t_default;
    trig;
    wait_idle;
    chk(stepLog, 24'hFFFFF0);
    rd(5'h00, 8'h02);
    rd(5'h04, 8'h80);
    rd(5'h05, 8'hEE);
    rd(5'h00, 8'h00);
  endtask
  task t_order;
    wr(5'h01, 8'h15);
    trig;
    wait_idle;
    chk(stepLog, 24'h012345);
    chk(24'(inSeen), 24'hF);
    chk(24'(diffSeen), 24'h0);
    rd(5'h00, 8'h7E);
    rd(5'h08, 8'h94);
    rd(5'h09, 8'h02);
    rd(5'h00, 8'h76);
    rd(5'h0E, 8'h97);
    rd(5'h0F, 8'h05);
  endtask
  task t_remote;
    wr(5'h01, 8'h8B);
    trig;
    wait_idle;
    chk(stepLog, 24'hFFF013);
    chk(24'(biasSeen), 24'h1);
    chk(24'(inSeen), 24'hF);
    chk(24'(diffSeen), 24'h0A);
    rd(5'h04, 8'h92);
    rd(5'h06, 8'h93);
    rd(5'h0A, 8'h95);
  endtask
  task t_pause;
    wr(5'h01, 8'h00);
    trig;
    rd(5'h04, 8'h12);
    serialReadBusy <= 1'b1;
    repeat (40) @(posedge clk);
    #1 chk(24'(seqBusy), 24'h1);
    @(posedge clk);
    serialReadBusy <= 1'b0;
    wait_idle;
    rd(5'h04, 8'h80);
    trig;
    serialReadBusy <= 1'b1;
    rd(5'h00, 8'h21);
    wait_idle;
    serialReadBusy <= 1'b0;
  endtask
  task t_repeat;
    wr(5'h01, 8'h40);
    trig;
    repeat (90) @(posedge clk);
    #1 chk(24'(stepLog[11:0]), 24'h0);
    @(posedge clk);
    wr(5'h01, 8'h00);
    wait_idle;
  endtask
  task t_uv;
    wr(5'h01, 8'h15);
    uvDetect <= 1'b1;
    repeat (6) @(posedge clk);
    rd(5'h01, 8'h00);
    wr(5'h01, 8'h15);
    uvDetect <= 1'b0;
    repeat (4) @(posedge clk);
    rd(5'h01, 8'h00);
    chk(24'(inputEn), 24'h0);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_default;
    t_order;
    t_remote;
    t_pause;
    t_repeat;
    t_uv;
    tally_and_finish;
  end
  // whole run is under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
